// *** sram_ctl_cfg.svh ***
`ifndef SRAM_CTL_CFG_SVH
`define SRAM_CTL_CFG_SVH

// Clock and timing figures
`define CLK_PERIOD_NS      50
`define ACCESS_TIME_NS     20
`define ACCESS_CYCLES      ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS     12
`define WRITE_CYCLES       ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TURN_TIME_NS       9
`define TURN_CYCLES        ((`TURN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Memory geometry
`define ADDR_WIDTH         17
`define DATA_WIDTH         8

`endif

// *** sram_ctl_pkg.sv ***
package sram_ctl_pkg;

    // Controller sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_RSET  = 6'b00_0010,
        ST_RWAIT = 6'b00_0100,
        ST_WSET  = 6'b00_1000,
        ST_WPULS = 6'b01_0000,
        ST_TURN  = 6'b10_0000
    } ctl_state_t;

endpackage

// *** sram_host_ctl.sv ***
`timescale 1ns/10ps
`include "sram_ctl_cfg.svh"

// Behaviour
// - Write strobe held high during reads
// - Address valid before select falls
// - Address reads keep select, enable low
// - Host never drives while memory drives
module sram_host_ctl #(
    parameter int ADDR_W = `ADDR_WIDTH,
    parameter int DATA_W = `DATA_WIDTH
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              req_valid_in,
    input  wire logic              req_write_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [DATA_W-1:0] req_wdata_in,
    output logic                   req_ready_out,
    output logic                   rd_valid_out,
    output logic [DATA_W-1:0]      rd_data_out,
    output logic [ADDR_W-1:0]      address_lines_out,
    output logic                   chip_sel_n_out,
    output logic                   write_strobe_n_out,
    output logic                   out_drive_n_out,
    input  wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0]      data_lines_out,
    output logic                   data_lines_oe_out
);
    import sram_ctl_pkg::*;

    localparam logic [3:0] ACC_CNT  = 4'(`ACCESS_CYCLES);
    localparam logic [3:0] WR_CNT   = 4'(`WRITE_CYCLES);
    localparam logic [3:0] TURN_CNT = 4'(`TURN_CYCLES);

    // ------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------
    ctl_state_t        state_r;
    ctl_state_t        state_nxt;
    logic [3:0]        cnt_r;
    logic [3:0]        cnt_nxt;
    logic [DATA_W-1:0] sync1_r;
    logic [DATA_W-1:0] sync2_r;

    // Request accepted only when idle, so one access is in flight
    wire take_w   = req_valid_in && (state_r == ST_IDLE);
    wire cnt_done = (cnt_r == 4'h0);

    // ------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_done ? 4'h0 : cnt_r - 4'h1;
        case (state_r)
            ST_IDLE: begin
                if (take_w) begin
                    state_nxt = req_write_in ? ST_WSET : ST_RSET;
                    cnt_nxt   = req_write_in ? WR_CNT : ACC_CNT;
                end
            end
            ST_RSET: begin
                // Reload stretches the read past the synchroniser delay
                state_nxt = ST_RWAIT;
                cnt_nxt   = cnt_r + 4'h2;
            end
            ST_RWAIT: begin
                // Two extra cycles cover the data synchroniser
                if (cnt_done) begin
                    state_nxt = ST_TURN;
                    cnt_nxt   = TURN_CNT;
                end
            end
            ST_WSET:  state_nxt = ST_WPULS;
            ST_WPULS: begin
                if (cnt_done) begin
                    state_nxt = ST_TURN;
                    cnt_nxt   = TURN_CNT;
                end
            end
            ST_TURN:  if (cnt_done) state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // Write decode is shared by the strobe, the bus drive and the checks
    function automatic logic is_write_state(input ctl_state_t s);
        return (s == ST_WSET) || (s == ST_WPULS);
    endfunction

    // Read phase is stretched by the two synchroniser stages
    wire rd_phase   = (state_r == ST_RSET) || (state_r == ST_RWAIT);
    wire wr_phase   = is_write_state(state_r);
    wire rd_capture = (state_r == ST_RWAIT) && cnt_done;
    wire wr_next    = is_write_state(state_nxt);
    wire rd_next    = (state_nxt == ST_RWAIT);
    // Bus stays driven one cycle past the strobe: zero hold time, no race
    wire hold_data  = (state_r == ST_WPULS);

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Read data arrives from pins, so it passes two flops first
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= data_lines_in;
            sync2_r <= sync1_r;
        end
    end

    // ------------------------------------------------------------
    // Pin drive; all outputs registered
    // ------------------------------------------------------------
    // Address set a cycle before select falls and held to the end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            address_lines_out  <= '0;
            chip_sel_n_out     <= 1'b1;
            write_strobe_n_out <= 1'b1;
            out_drive_n_out    <= 1'b1;
            data_lines_out     <= '0;
            data_lines_oe_out  <= 1'b0;
        end else begin
            if (take_w) begin
                address_lines_out <= req_addr_in;
                data_lines_out    <= req_wdata_in;
            end
            chip_sel_n_out     <= !(rd_next || state_nxt == ST_WPULS);
            write_strobe_n_out <= !wr_next;
            out_drive_n_out    <= !rd_next;
            data_lines_oe_out  <= wr_next || hold_data;
        end
    end

    // Read word returned to the user with a one-cycle valid
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_valid_out  <= 1'b0;
            rd_data_out   <= '0;
            req_ready_out <= 1'b0;
        end else begin
            rd_valid_out  <= rd_capture;
            if (rd_capture)
                rd_data_out <= sync2_r;
            req_ready_out <= (state_nxt == ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence write_pulse_s;
        !write_strobe_n_out && !chip_sel_n_out;
    endsequence

    // Write close: select up with data still driven, released a cycle later
    sequence wr_tail_s;
        chip_sel_n_out && data_lines_oe_out ##1 !data_lines_oe_out;
    endsequence

    rd_strobe_high_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !out_drive_n_out |-> write_strobe_n_out)
        else $error("write strobe low during read");

    no_contend_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !out_drive_n_out |-> !data_lines_oe_out)
        else $error("host drives data while memory drives");

    strobe_first_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $fell(chip_sel_n_out) && !out_drive_n_out |-> write_strobe_n_out)
        else $error("read select with strobe low");

    wr_data_held_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        write_pulse_s |-> data_lines_oe_out && $stable(data_lines_out))
        else $error("write data not driven during pulse");

    addr_stable_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !chip_sel_n_out && !$fell(chip_sel_n_out) |-> $stable(address_lines_out))
        else $error("address moved during access");

    desel_quiet_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        chip_sel_n_out |-> out_drive_n_out)
        else $error("output enable low while deselected");

    rd_valid_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $fell(out_drive_n_out) |-> ##[1:8] rd_valid_out)
        else $error("read never completed");

    wr_release_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(write_strobe_n_out) |-> wr_tail_s)
        else $error("write end order wrong");

    rd_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_phase && !chip_sel_n_out |-> !out_drive_n_out && write_strobe_n_out)
        else $error("read pins moved while selected");

    wr_drive_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_phase |-> data_lines_oe_out && !write_strobe_n_out)
        else $error("write phase without bus drive");

    wr_order_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $fell(chip_sel_n_out) && !write_strobe_n_out |-> !$past(write_strobe_n_out))
        else $error("select fell before write strobe");

endmodule

// *** sram_dev_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Behavioural static memory at the far side
// ----------------------------------------
module sram_dev_model (
    input  wire logic [16:0] address_lines_in,
    input  wire logic        chip_sel_n_in,
    input  wire logic        write_strobe_n_in,
    input  wire logic        out_drive_n_in,
    input  wire logic [7:0]  bus_in,
    output logic [7:0]       data_lines_out,
    output logic             drive_out
);
    logic [7:0] mem_r [131072];
    logic [7:0] last_r = 8'h00;
    logic       quiet_r = 1'b0;
    // Select falling under a low strobe keeps the outputs off for that access
    always @(negedge chip_sel_n_in) quiet_r = !write_strobe_n_in;
    // Word takes whatever the bus holds when the overlap ends
    always @(posedge (chip_sel_n_in | write_strobe_n_in)) begin
        mem_r[address_lines_in] = bus_in;
    end
    // Drive only in read mode; deselect and output-disable float
    assign drive_out = !chip_sel_n_in && write_strobe_n_in && !out_drive_n_in
                       && !quiet_r;
    // Released lines show the inverse, so a held stale value cannot pass
    always @* if (drive_out) last_r = mem_r[address_lines_in];
    assign data_lines_out = drive_out ? mem_r[address_lines_in] : ~last_r;
endmodule

// *** test_async_static_ram_access.sv ***
`timescale 1ns/10ps
module test_async_static_ram_access;
    logic        mclk_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0;
    logic [16:0] req_addr_in = '0, address_lines_out, pool [8];
    logic [7:0]  req_wdata_in = '0, rd_data_out, data_lines_out, mem_data;
    logic        req_ready_out, rd_valid_out, chip_sel_n_out, write_strobe_n_out;
    logic        out_drive_n_out, data_lines_oe_out, mem_drive;
    wire  [7:0]  data_lines_in = data_lines_oe_out ? data_lines_out : mem_data;
    logic [7:0]  ref_q [int];
    logic [31:0] seed = 32'h9674_6d63;
    int          n_errors = 0, checked = 0;
    // ----------------------------------------
    // Clock, design and partner
    // ----------------------------------------
    always #25 mclk_in = ~mclk_in;
    sram_host_ctl dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
        .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
        .address_lines_out(address_lines_out), .chip_sel_n_out(chip_sel_n_out),
        .write_strobe_n_out(write_strobe_n_out), .out_drive_n_out(out_drive_n_out),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
        .data_lines_oe_out(data_lines_oe_out));
    sram_dev_model mem_u (.address_lines_in(address_lines_out),
        .chip_sel_n_in(chip_sel_n_out), .write_strobe_n_in(write_strobe_n_out),
        .out_drive_n_in(out_drive_n_out), .bus_in(data_lines_in),
        .data_lines_out(mem_data), .drive_out(mem_drive));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Pins sampled mid-cycle: both sides on the bus at once is a collision
    always @(negedge mclk_in) if (!rst_in) begin
        chk(!(data_lines_oe_out === 1'b1 && mem_drive), "bus driven by both sides");
        chk(!(out_drive_n_out === 1'b0 && write_strobe_n_out !== 1'b1), "strobe low in read");
    end
    // One request: held until taken, then a read waits for its data pulse
    task automatic req(input logic w, input logic [16:0] a, input logic [7:0] d);
        int k;
        @(posedge mclk_in);
        req_valid_in <= 1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        k = 0;
        do begin @(posedge mclk_in); k++; end while (req_ready_out !== 1'b1 && k < 40);
        req_valid_in <= 0;
        if (k >= 40) begin chk(0, "request never taken"); close_out; end
        if (w) ref_q[a] = d;
        else begin
            k = 0;
            do begin @(posedge mclk_in); k++; end while (rd_valid_out !== 1'b1 && k < 40);
            if (k >= 40) begin chk(0, "read data never came"); close_out; end
            chk(rd_data_out === ref_q[a], "read data wrong");
        end
    endtask
    // ----------------------------------------
    // Main sequence: fill a pool incl. both address ends, then random mix
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 0;
        repeat (2) @(posedge mclk_in);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            pool[i] = (i == 0) ? 17'h0_0000 : (i == 7) ? 17'h1_FFFF : seed[16:0];
            req(1'b1, pool[i], seed[31:24]);
        end
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            req(seed[0], pool[seed[3:1]], seed[15:8]);
        end
        close_out;
    end
endmodule
